// *** core/pmm_pkg.sv ***
// Purpose: Shared constants and types of the protection mode manager.
// Assumes: 40 MHz system clock; settings bytes are eight bits wide.
// Notes:   Settings indices, field positions and defaults live here.
package pmm_pkg;

  localparam int CLK_HZ        = 40000000;
  localparam int MS_PER_S      = 1000;
  localparam int MS_CYC        = CLK_HZ / MS_PER_S;
  localparam int REPEAT_CLR_S  = 65;
  localparam int REPEAT_CLR_MS = REPEAT_CLR_S * MS_PER_S;
  localparam int RAMP_CYC      = 4;

  // Soft-start periods and discharge delays in ms.
  localparam logic [15:0] SS_MS0 = 16'd13;
  localparam logic [15:0] SS_MS1 = 16'd25;
  localparam logic [15:0] SS_MS2 = 16'd51;
  localparam logic [15:0] SS_MS3 = 16'd102;
  localparam logic [15:0] XC_MS1 = 16'd100;
  localparam logic [15:0] XC_MS2 = 16'd200;
  localparam logic [15:0] XC_MS3 = 16'd400;

  // Settings byte indices.
  localparam int NV_N = 12;
  localparam logic [3:0] NV_PMAX  = 4'h0;
  localparam logic [3:0] NV_OFF1  = 4'h1;
  localparam logic [3:0] NV_OFF2  = 4'h2;
  localparam logic [3:0] NV_TMR1  = 4'h3;
  localparam logic [3:0] NV_TMR2  = 4'h4;
  localparam logic [3:0] NV_OPPC  = 4'h5;
  localparam logic [3:0] NV_MISC  = 4'h6;
  localparam logic [3:0] NV_POL   = 4'h7;
  localparam logic [3:0] NV_SAFE  = 4'h8;
  localparam logic [3:0] NV_FLR   = 4'h9;
  localparam logic [3:0] NV_LOCK  = 4'ha;
  localparam logic [3:0] NV_CUST  = 4'hb;

  // Field positions.
  localparam int OPPC_POL_LO = 0;
  localparam int OPPC_REP_LO = 2;
  localparam int OPPC_EN1    = 6;
  localparam int OPPC_EN2    = 7;
  localparam int MISC_S12    = 0;
  localparam int MISC_SS_LO  = 1;
  localparam int MISC_XC_LO  = 3;
  localparam int MISC_PM_LO  = 5;
  localparam int MISC_WEN    = 7;
  localparam int LOCK_RD     = 0;
  localparam int LOCK_WR     = 1;

  localparam logic [1:0] POL_LATCH = 2'h0;
  localparam logic [1:0] POL_SAFE  = 2'h1;
  localparam logic [1:0] POL_LAS   = 2'h2;
  localparam logic [1:0] PM_OFF    = 2'h3;

  // Customer code default is arbitrary.
  localparam logic [NV_N-1:0][7:0] NV_DEFAULT = {
    8'h00, 8'h00, 8'h64, 8'hfa, 8'h55, 8'h08,
    8'hcd, 8'hc8, 8'h32, 8'h32, 8'h14, 8'haa};

  // Cause bits and synchronised input bits.
  localparam int CS_N   = 6;
  localparam int CS_OPP1 = 0;
  localparam int CS_OPP2 = 1;
  localparam int CS_OVP  = 2;
  localparam int CS_OCP  = 3;
  localparam int CS_UVP  = 4;
  localparam int CS_OTP  = 5;
  localparam int IN_N    = 12;
  localparam int IN_OVP  = 0;
  localparam int IN_OCP  = 1;
  localparam int IN_UVP  = 2;
  localparam int IN_OTP  = 3;
  localparam int IN_BLOW = 4;
  localparam int IN_OTW  = 5;
  localparam int IN_OVW  = 6;
  localparam int IN_BOW  = 7;
  localparam int IN_BO   = 8;
  localparam int IN_ML   = 9;
  localparam int IN_SUV  = 10;
  localparam int IN_SOK  = 11;

  typedef enum logic [1:0] {ST_START, ST_RUN, ST_WAIT, ST_LATCH} pmm_state_t;

  typedef struct packed {
    logic [IN_N-1:0]       sync1;
    logic [IN_N-1:0]       sync2;
    logic [NV_N-1:0][7:0]  nv;
    pmm_state_t            st;
    logic [15:0]           pre;
    logic                  tick;
    logic [7:0]            c1;
    logic [7:0]            c2;
    logic [3:0]            rep;
    logic [15:0]           quiet;
    logic [15:0]           wt;
    logic [15:0]           bo;
    logic [15:0]           ssc;
    logic [15:0]           xc;
    logic [CS_N-1:0]       cause;
    logic [7:0]            fb;
    logic [1:0]            ramp;
    logic                  llc_en;
    logic                  pfc_en;
    logic                  latched;
    logic                  limit;
    logic                  ss;
    logic                  xcap;
    logic                  hv_chg;
    logic [7:0]            rdata;
    logic                  rvalid;
    logic                  rref;
    logic                  wref;
  } pmm_regs_t;

endpackage

// *** core/pmm_top.sv ***
// Purpose: Overpower handling, protection policies, power-good ramp and settings.
// Assumes: pwr_i is a same-clock percentage of rated power; sense flags are pins.
// Notes:   Settings store is a byte array reached by plain read and write strobes.
// Contract
// [R1] Above maximum power, limit each cycle.
// [R2] First level: timed trip, disableable.
// [R3] Second level: own timed trip, disableable.
// [R4] Each protection picks one of three policies.
// [R5] Latched resumes on fast reset or supply.
// [R6] Safe restart waits one shared delay.
// [R7] Repeat counter latches at configured count.
// [R8] Quiet sixty-five seconds clears repeat counter.
// [R9] Long brownout restarts, even from latch.
// [R10] Indicator high at start-up, low running.
// [R11] Five warnings raise the indicator.
// [R12] Indicator moves along a ramp.
// [R13] Overvoltage, overcurrent, undervoltage: high at once.
// [R14] Sticky cause record, cleared by software.
// [R15] Twelve volt start disables charge path.
// [R16] Read lock refuses reads; default allowed.
// [R17] Write lock blocks writes; default allowed.
// [R18] Default loads all values, unlocks settings.
// [R19] Customer code always readable.
// [R20] Four PFC soft-start periods.
// [R21] Delayed X-capacitor discharge, or never.
// [R22] Four PFC operating modes.
`timescale 1ns/1ps
module pmm_top #(
  parameter int MS_CYCLES = pmm_pkg::MS_CYC,
  parameter int QUIET_MS  = pmm_pkg::REPEAT_CLR_MS
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // Power measurement.
  input  wire logic [7:0]  pwr_i,
  // Protection and warning sense pins.
  input  wire logic        ovp_i,
  input  wire logic        ocp_i,
  input  wire logic        uvp_i,
  input  wire logic        otp_i,
  input  wire logic        boost_low_i,
  input  wire logic        otp_warn_i,
  input  wire logic        ovp_warn_i,
  input  wire logic        bo_warn_i,
  input  wire logic        brownout_i,
  input  wire logic        mains_lost_i,
  input  wire logic        supply_uv_i,
  input  wire logic        supply_ok_i,
  // Settings access.
  input  wire logic        nv_wr_i,
  input  wire logic        nv_rd_i,
  input  wire logic [3:0]  nv_addr_i,
  input  wire logic [7:0]  nv_wdata_i,
  input  wire logic        nv_default_i,
  input  wire logic        cause_clr_i,
  output logic [7:0]       nv_rdata_o,
  output logic             nv_rvalid_o,
  output logic             nv_rd_refused_o,
  output logic             nv_wr_refused_o,
  // Converter control and status.
  output logic             llc_en_o,
  output logic             pfc_en_o,
  output logic             power_limit_o,
  output logic [7:0]       feedback_sense_pin_o,
  output logic             latched_o,
  output logic [5:0]       cause_o,
  output logic [3:0]       repeat_cnt_o,
  output logic             hv_startup_charge_path_o,
  output logic             start_12v_o,
  output logic             pfc_softstart_o,
  output logic [1:0]       pfc_mode_o,
  output logic             xcap_dch_o
);

  pmm_pkg::pmm_regs_t s;
  pmm_pkg::pmm_regs_t next_s;

  wire logic [pmm_pkg::IN_N-1:0] pins = {supply_ok_i, supply_uv_i, mains_lost_i, brownout_i,
    bo_warn_i, ovp_warn_i, otp_warn_i, boost_low_i, otp_i, uvp_i, ocp_i, ovp_i};

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb begin
    logic [pmm_pkg::IN_N-1:0] in;
    logic [7:0]               pmax;
    logic [7:0]               thr1;
    logic [7:0]               thr2;
    logic [7:0]               misc;
    logic                     over1;
    logic                     over2;
    logic                     near;
    logic                     warn;
    logic                     hard;
    logic [pmm_pkg::CS_N-1:0] trig;
    logic [1:0]               pol;
    logic [3:0]               rep_new;
    logic [15:0]              ss_tgt;
    logic [15:0]              xc_tgt;
    logic                     up;
    next_s  = s;
    over1   = 1'b0;
    over2   = 1'b0;
    near    = 1'b0;
    warn    = 1'b0;
    hard    = 1'b0;
    trig    = '0;
    up      = 1'b0;
    in      = s.sync2;
    pmax    = s.nv[pmm_pkg::NV_PMAX];
    misc    = s.nv[pmm_pkg::NV_MISC];
    thr1    = (s.nv[pmm_pkg::NV_OFF1] > pmax) ? 8'h00 : 8'(pmax - s.nv[pmm_pkg::NV_OFF1]);
    thr2    = (s.nv[pmm_pkg::NV_OFF2] > pmax) ? 8'h00 : 8'(pmax - s.nv[pmm_pkg::NV_OFF2]);
    pol     = pmm_pkg::POL_LATCH;
    rep_new = 4'(s.rep + 4'h1);
    ss_tgt  = pmm_pkg::SS_MS0;
    xc_tgt  = 16'h0000;
    next_s.sync1 = pins;
    next_s.sync2 = s.sync1;

    next_s.tick = (s.pre == 16'(MS_CYCLES - 1));
    next_s.pre  = next_s.tick ? 16'h0000 : 16'(s.pre + 16'h0001);

    next_s.limit = (s.st == pmm_pkg::ST_RUN) && (pwr_i > pmax); // R1

    // Overpower timers count ms while above their threshold.
    over1 = s.nv[pmm_pkg::NV_OPPC][pmm_pkg::OPPC_EN1] && (pwr_i > thr1)
            && (s.st == pmm_pkg::ST_RUN);
    over2 = s.nv[pmm_pkg::NV_OPPC][pmm_pkg::OPPC_EN2] && (pwr_i > thr2)
            && (s.st == pmm_pkg::ST_RUN);
    next_s.c1 = !over1 ? 8'h00 : (s.tick && s.c1 != 8'hff) ? 8'(s.c1 + 8'h01) : s.c1; // R2
    next_s.c2 = !over2 ? 8'h00 : (s.tick && s.c2 != 8'hff) ? 8'(s.c2 + 8'h01) : s.c2; // R3
    trig = '0;
    trig[pmm_pkg::CS_OPP1] = over1 && (s.c1 >= s.nv[pmm_pkg::NV_TMR1]); // R2
    trig[pmm_pkg::CS_OPP2] = over2 && (s.c2 >= s.nv[pmm_pkg::NV_TMR2]); // R3
    trig[pmm_pkg::CS_OVP]  = in[pmm_pkg::IN_OVP] && (s.st == pmm_pkg::ST_RUN);
    trig[pmm_pkg::CS_OCP]  = in[pmm_pkg::IN_OCP] && (s.st == pmm_pkg::ST_RUN);
    trig[pmm_pkg::CS_UVP]  = in[pmm_pkg::IN_UVP] && (s.st == pmm_pkg::ST_RUN);
    trig[pmm_pkg::CS_OTP]  = in[pmm_pkg::IN_OTP] && (s.st == pmm_pkg::ST_RUN);
    hard = trig[pmm_pkg::CS_OVP] | trig[pmm_pkg::CS_OCP] | trig[pmm_pkg::CS_UVP];

    // Policy of the lowest-numbered cause that fired.
    for (int i = pmm_pkg::CS_N - 1; i >= 0; i--) begin
      if (trig[i]) begin
        if (i <= pmm_pkg::CS_OPP2) begin
          pol = s.nv[pmm_pkg::NV_OPPC][pmm_pkg::OPPC_POL_LO +: 2]; // R4
        end else begin
          pol = s.nv[pmm_pkg::NV_POL][2*(i-pmm_pkg::CS_OVP) +: 2]; // R4
        end
      end
    end

    // Set wins over a simultaneous clear.
    next_s.cause = (s.cause & ~{pmm_pkg::CS_N{cause_clr_i}}) | trig; // R14

    // Quiet timer clears the repeat counter.
    if (|trig) begin
      next_s.quiet = 16'h0000;
    end else if (s.tick) begin
      if (s.quiet >= 16'(QUIET_MS - 1)) begin
        next_s.quiet = 16'h0000; // R8
        next_s.rep   = 4'h0; // R8
      end else begin
        next_s.quiet = 16'(s.quiet + 16'h0001);
      end
    end

    next_s.bo = !in[pmm_pkg::IN_BO] ? 16'h0000 :
                (s.tick && s.bo != 16'hffff) ? 16'(s.bo + 16'h0001) : s.bo;
    next_s.wt = (s.tick && s.wt != 16'hffff) ? 16'(s.wt + 16'h0001) : s.wt;

    unique case (s.st)
      pmm_pkg::ST_START: begin
        if (in[pmm_pkg::IN_SOK] && !in[pmm_pkg::IN_BLOW]) begin
          next_s.st = pmm_pkg::ST_RUN;
        end
      end
      pmm_pkg::ST_RUN: begin
        if (|trig) begin
          next_s.wt = 16'h0000;
          if (pol == pmm_pkg::POL_SAFE) begin
            next_s.st = pmm_pkg::ST_WAIT; // R6
          end else if (pol == pmm_pkg::POL_LAS) begin
            next_s.rep = rep_new; // R7
            next_s.st  = (rep_new >= s.nv[pmm_pkg::NV_OPPC][pmm_pkg::OPPC_REP_LO +: 4]) ?
                         pmm_pkg::ST_LATCH : pmm_pkg::ST_WAIT; // R7
          end else begin
            next_s.st = pmm_pkg::ST_LATCH; // R5
          end
        end
      end
      pmm_pkg::ST_WAIT: begin
        if (s.wt >= 16'(s.nv[pmm_pkg::NV_SAFE])) begin
          next_s.st = pmm_pkg::ST_START; // R6
        end
      end
      pmm_pkg::ST_LATCH: begin
        if (in[pmm_pkg::IN_SUV]) begin
          next_s.st = pmm_pkg::ST_START; // R5
        end
      end
    endcase
    if ((s.st == pmm_pkg::ST_WAIT || s.st == pmm_pkg::ST_LATCH)
        && in[pmm_pkg::IN_BO] && s.bo >= 16'(s.nv[pmm_pkg::NV_FLR])) begin
      next_s.st = pmm_pkg::ST_START; // R9
    end

    // Switch enables follow the next state.
    next_s.llc_en = (next_s.st == pmm_pkg::ST_RUN);
    next_s.pfc_en = (next_s.st == pmm_pkg::ST_RUN || next_s.st == pmm_pkg::ST_START)
                    && (misc[pmm_pkg::MISC_PM_LO +: 2] != pmm_pkg::PM_OFF); // R22
    next_s.latched = (next_s.st == pmm_pkg::ST_LATCH); // R5

    // Power-good indicator.
    near = (over1 && s.c1 >= 8'(s.nv[pmm_pkg::NV_TMR1] - (s.nv[pmm_pkg::NV_TMR1] >> 2)))
        || (over2 && s.c2 >= 8'(s.nv[pmm_pkg::NV_TMR2] - (s.nv[pmm_pkg::NV_TMR2] >> 2)));
    warn = in[pmm_pkg::IN_BLOW] || near || in[pmm_pkg::IN_OTW]
        || (misc[pmm_pkg::MISC_WEN] && (in[pmm_pkg::IN_OVW] || in[pmm_pkg::IN_BOW])); // R11
    up = (s.st != pmm_pkg::ST_RUN) || warn; // R10
    next_s.ramp = 2'(s.ramp + 2'h1);
    if (hard) begin
      next_s.fb   = 8'hff; // R13
      next_s.ramp = 2'h0;
    end else if (s.ramp == 2'(pmm_pkg::RAMP_CYC - 1)) begin
      if (up && s.fb != 8'hff) begin
        next_s.fb = 8'(s.fb + 8'h01); // R12
      end else if (!up && s.fb != 8'h00) begin
        next_s.fb = 8'(s.fb - 8'h01); // R12
      end
    end

    // PFC soft-start window from start-up.
    unique case (misc[pmm_pkg::MISC_SS_LO +: 2])
      2'h0: ss_tgt = pmm_pkg::SS_MS0; // R20
      2'h1: ss_tgt = pmm_pkg::SS_MS1; // R20
      2'h2: ss_tgt = pmm_pkg::SS_MS2; // R20
      2'h3: ss_tgt = pmm_pkg::SS_MS3; // R20
    endcase
    next_s.ssc = !next_s.pfc_en ? 16'h0000 :
                 (s.tick && s.ssc != 16'hffff) ? 16'(s.ssc + 16'h0001) : s.ssc;
    next_s.ss  = next_s.pfc_en && (s.ssc < ss_tgt);

    // X-capacitor discharge after mains loss.
    unique case (misc[pmm_pkg::MISC_XC_LO +: 2])
      2'h0: xc_tgt = 16'h0000;
      2'h1: xc_tgt = pmm_pkg::XC_MS1; // R21
      2'h2: xc_tgt = pmm_pkg::XC_MS2; // R21
      2'h3: xc_tgt = pmm_pkg::XC_MS3; // R21
    endcase
    next_s.xc   = !in[pmm_pkg::IN_ML] ? 16'h0000 :
                  (s.tick && s.xc != 16'hffff) ? 16'(s.xc + 16'h0001) : s.xc;
    next_s.xcap = (xc_tgt != 16'h0000) && in[pmm_pkg::IN_ML] && (s.xc >= xc_tgt); // R21

    next_s.hv_chg = !misc[pmm_pkg::MISC_S12]; // R15

    // Settings access.
    next_s.rvalid = nv_rd_i;
    next_s.rref   = 1'b0;
    next_s.wref   = 1'b0;
    next_s.rdata  = 8'h00;
    if (nv_rd_i && nv_addr_i < 4'(pmm_pkg::NV_N)) begin
      if (nv_addr_i == pmm_pkg::NV_CUST) begin
        next_s.rdata = s.nv[nv_addr_i]; // R19
      end else if (s.nv[pmm_pkg::NV_LOCK][pmm_pkg::LOCK_RD]) begin
        next_s.rref = 1'b1; // R16
      end else begin
        next_s.rdata = s.nv[nv_addr_i];
      end
    end
    if (nv_default_i) begin
      next_s.nv = pmm_pkg::NV_DEFAULT; // R18
    end else if (nv_wr_i) begin
      if (s.nv[pmm_pkg::NV_LOCK][pmm_pkg::LOCK_WR] || nv_addr_i >= 4'(pmm_pkg::NV_N)) begin
        next_s.wref = 1'b1; // R17
      end else begin
        next_s.nv[nv_addr_i] = nv_wdata_i;
      end
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s        <= '0;
      s.nv     <= pmm_pkg::NV_DEFAULT;
      s.fb     <= 8'hff;
      s.hv_chg <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign nv_rdata_o               = s.rdata;
  assign nv_rvalid_o              = s.rvalid;
  assign nv_rd_refused_o          = s.rref;
  assign nv_wr_refused_o          = s.wref;
  assign llc_en_o                 = s.llc_en;
  assign pfc_en_o                 = s.pfc_en;
  assign power_limit_o            = s.limit;
  assign feedback_sense_pin_o     = s.fb;
  assign latched_o                = s.latched;
  assign cause_o                  = s.cause;
  assign repeat_cnt_o             = s.rep;
  assign hv_startup_charge_path_o = s.hv_chg;
  assign start_12v_o              = s.nv[pmm_pkg::NV_MISC][pmm_pkg::MISC_S12];
  assign pfc_softstart_o          = s.ss;
  assign pfc_mode_o               = s.nv[pmm_pkg::NV_MISC][pmm_pkg::MISC_PM_LO +: 2];
  assign xcap_dch_o               = s.xcap;

endmodule // pmm_top

// *** verif/pmm_monitor.sv ***
// Purpose: Port-level checks of the protection mode manager.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound onto pmm_top after the module.
`timescale 1ns/1ps
module pmm_monitor (
  // Clock and reset.
  input wire logic       clk_i,
  input wire logic       srst_i,
  // Watched inputs.
  input wire logic       nv_rd_i,
  input wire logic       nv_wr_i,
  input wire logic       nv_default_i,
  input wire logic       cause_clr_i,
  input wire logic       mains_lost_i,
  input wire logic [3:0] nv_addr_i,
  // Watched outputs.
  input wire logic [7:0] nv_rdata_o,
  input wire logic       nv_rvalid_o,
  input wire logic       nv_rd_refused_o,
  input wire logic       nv_wr_refused_o,
  input wire logic       llc_en_o,
  input wire logic       pfc_en_o,
  input wire logic [7:0] feedback_sense_pin_o,
  input wire logic       latched_o,
  input wire logic [5:0] cause_o,
  input wire logic [3:0] repeat_cnt_o,
  input wire logic       hv_startup_charge_path_o,
  input wire logic       start_12v_o,
  input wire logic       xcap_dch_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // ****
  // Sequences and properties
  // ****
  sequence s_new_cause; (cause_o & ~$past(cause_o)) != 6'h00; endsequence
  sequence s_new_hard; (cause_o[4:2] & ~$past(cause_o[4:2])) != 3'h0; endsequence
  sequence s_fb_step;
    $changed(feedback_sense_pin_o) && feedback_sense_pin_o != 8'hff;
  endsequence
  property p_trip_stop; s_new_cause |-> !llc_en_o && !pfc_en_o; endproperty
  property p_hard_stop; s_new_hard |-> feedback_sense_pin_o == 8'hff; endproperty
  property p_sticky; (($past(cause_o) & ~cause_o) != 6'h00) |-> $past(cause_clr_i); endproperty
  property p_latch_off; latched_o |-> !llc_en_o && !pfc_en_o; endproperty
  property p_rep_step;
    $changed(repeat_cnt_o) |-> repeat_cnt_o == $past(repeat_cnt_o) + 4'h1 || repeat_cnt_o == 4'h0;
  endproperty
  property p_fb_ramp;
    s_fb_step |-> $past(feedback_sense_pin_o) == $past(feedback_sense_pin_o, 2);
  endproperty
  property p_rd_refuse;
    nv_rd_refused_o |-> nv_rdata_o == 8'h00 && $past(nv_rd_i) && $past(nv_addr_i) != 4'hb;
  endproperty
  property p_cust_rd; nv_rd_i && nv_addr_i == 4'hb |=> nv_rvalid_o && !nv_rd_refused_o; endproperty
  property p_wr_range; nv_wr_i && !nv_default_i && nv_addr_i >= 4'hc |=> nv_wr_refused_o; endproperty
  property p_12v; start_12v_o [*2] |-> !hv_startup_charge_path_o; endproperty
  property p_xcap; xcap_dch_o |-> $past(mains_lost_i, 3); endproperty
  // ****
  // Assertions
  // ****
  a_trip_stop: assert property (p_trip_stop) else $error("stop missing on trip");
  a_hard_stop: assert property (p_hard_stop) else $error("indicator not high at once");
  a_sticky: assert property (p_sticky) else $error("cause record lost");
  a_latch_off: assert property (p_latch_off) else $error("switching while latched");
  a_rep_step: assert property (p_rep_step) else $error("repeat counter jump");
  a_fb_ramp: assert property (p_fb_ramp) else $error("indicator step too soon");
  a_rd_refuse: assert property (p_rd_refuse) else $error("bad refused read");
  a_cust_rd: assert property (p_cust_rd) else $error("customer code refused");
  a_wr_range: assert property (p_wr_range) else $error("bad write accepted");
  a_12v: assert property (p_12v) else $error("charge path on at low start");
  a_xcap: assert property (p_xcap) else $error("discharge without mains loss");
endmodule // pmm_monitor

bind pmm_top pmm_monitor u_pmm_monitor (
  .clk_i, .srst_i, .nv_rd_i, .nv_wr_i, .nv_default_i, .cause_clr_i, .mains_lost_i,
  .nv_addr_i, .nv_rdata_o, .nv_rvalid_o, .nv_rd_refused_o, .nv_wr_refused_o,
  .llc_en_o, .pfc_en_o, .feedback_sense_pin_o, .latched_o, .cause_o, .repeat_cnt_o,
  .hv_startup_charge_path_o, .start_12v_o, .xcap_dch_o
);

// *** verif/pmm_stage_model.sv ***
// Purpose: Power stage sense model driving power and sense levels.
// Assumes: Levels change at the falling clock edge.
// Notes:   Supply undervoltage pulls the supply-good level low.
`timescale 1ns/1ps
module pmm_stage_model (
  // Clock.
  input wire logic         clk_i,
  // Commanded levels.
  input wire logic [7:0]   pwr_set_i,
  input wire logic [11:0]  sense_set_i,
  // Stage levels.
  output logic [7:0]       pwr_o = 8'h00,
  output logic [11:0]      sense_o = 12'h000
);
  always @(negedge clk_i) begin
    pwr_o <= pwr_set_i;
    sense_o <= sense_set_i;
    if (sense_set_i[10]) begin
      sense_o[11] <= 1'b0;
    end
  end
endmodule // pmm_stage_model

// *** verif/testbench.sv ***
// Purpose: Self-checking bench of the protection mode manager.
// Assumes: Short millisecond and quiet counts set by parameters.
// Notes:   Inputs change at the falling clock edge.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        nv_wr_i = 1'b0, nv_rd_i = 1'b0, nv_default_i = 1'b0, cause_clr_i = 1'b0;
  logic [3:0]  nv_addr_i = 4'h0;
  logic [7:0]  nv_wdata_i = 8'h00, pwr_set = 8'h00, pwr_i, nv_rdata_o, feedback_sense_pin_o;
  logic [11:0] sense_set = 12'h000, sense;
  logic        nv_rvalid_o, nv_rd_refused_o, nv_wr_refused_o, llc_en_o, pfc_en_o;
  logic        power_limit_o, latched_o, hv_startup_charge_path_o, start_12v_o, xcap_dch_o;
  logic [5:0]  cause_o;
  logic [3:0]  repeat_cnt_o;
  logic [1:0]  pfc_mode_o;
  logic        pfc_softstart_o;
  int          err_total = 0, checked = 0, cyc = 0;
  always #12.5 clk_i = ~clk_i;
  pmm_stage_model u_pmm_stage_model (.clk_i, .pwr_set_i(pwr_set), .sense_set_i(sense_set),
    .pwr_o(pwr_i), .sense_o(sense));
  pmm_top #(.MS_CYCLES(10), .QUIET_MS(20)) u_pmm_top (.clk_i, .srst_i, .pwr_i,
    .ovp_i(sense[0]), .ocp_i(sense[1]), .uvp_i(sense[2]), .otp_i(sense[3]),
    .boost_low_i(sense[4]), .otp_warn_i(sense[5]), .ovp_warn_i(sense[6]),
    .bo_warn_i(sense[7]), .brownout_i(sense[8]), .mains_lost_i(sense[9]),
    .supply_uv_i(sense[10]), .supply_ok_i(sense[11]), .nv_wr_i, .nv_rd_i, .nv_addr_i,
    .nv_wdata_i, .nv_default_i, .cause_clr_i, .nv_rdata_o, .nv_rvalid_o, .nv_rd_refused_o,
    .nv_wr_refused_o, .llc_en_o, .pfc_en_o, .power_limit_o, .feedback_sense_pin_o,
    .latched_o, .cause_o, .repeat_cnt_o, .hv_startup_charge_path_o, .start_12v_o,
    .pfc_softstart_o, .pfc_mode_o, .xcap_dch_o);
  // ****
  // Shared tasks
  // ****
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic r);
    @(negedge clk_i); nv_addr_i = a; nv_wdata_i = d; nv_wr_i = 1'b1;
    @(negedge clk_i); nv_wr_i = 1'b0;
    `CHK(nv_wr_refused_o, r)
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] d, input logic r);
    @(negedge clk_i); nv_addr_i = a; nv_rd_i = 1'b1;
    @(negedge clk_i); nv_rd_i = 1'b0;
    `CHK(nv_rvalid_o, 1'b1)
    `CHK(nv_rdata_o, d)
    `CHK(nv_rd_refused_o, r)
  endtask
  task automatic wait_llc(input logic v, input int lo, input int hi);
    int n;
    n = 0;
    while (llc_en_o !== v && n < hi) begin @(negedge clk_i); n++; end
    `CHK(n >= lo && n < hi, 1'b1)
  endtask
  task automatic results;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_locks;
    `CHK(feedback_sense_pin_o, 8'hff)
    for (int i = 0; i < pmm_pkg::NV_N; i++) rd(4'(i), pmm_pkg::NV_DEFAULT[i], 1'b0);
    wr(pmm_pkg::NV_CUST, 8'h5a, 1'b0);
    wr(pmm_pkg::NV_LOCK, 8'h03, 1'b0);
    rd(pmm_pkg::NV_PMAX, 8'h00, 1'b1);
    rd(pmm_pkg::NV_CUST, 8'h5a, 1'b0);
    wr(pmm_pkg::NV_PMAX, 8'h11, 1'b1);
    wr(4'hc, 8'h11, 1'b1);
    @(negedge clk_i); nv_default_i = 1'b1;
    @(negedge clk_i); nv_default_i = 1'b0;
    rd(pmm_pkg::NV_LOCK, 8'h00, 1'b0);
    rd(pmm_pkg::NV_PMAX, 8'haa, 1'b0);
  endtask
  task automatic t_opp;
    wr(pmm_pkg::NV_TMR1, 8'h02, 1'b0);
    wr(pmm_pkg::NV_SAFE, 8'h03, 1'b0);
    wr(pmm_pkg::NV_FLR, 8'h02, 1'b0);
    wr(pmm_pkg::NV_OPPC, 8'h4a, 1'b0);
    sense_set[11] = 1'b1;
    wait_llc(1'b1, 2, 20);
    repeat (1100) @(negedge clk_i);
    `CHK(feedback_sense_pin_o, 8'h00)
    `CHK(power_limit_o, 1'b0)
    pwr_set = 8'hb0;
    repeat (3) @(negedge clk_i);
    `CHK(power_limit_o, 1'b1)
    wait_llc(1'b0, 8, 40);
    `CHK(cause_o[0], 1'b1)
    `CHK(repeat_cnt_o, 4'h1)
    wait_llc(1'b1, 15, 45);
    wait_llc(1'b0, 8, 40);
    `CHK(latched_o, 1'b1)
    `CHK(repeat_cnt_o, 4'h2)
    pwr_set = 8'h00;
    repeat (100) @(negedge clk_i);
    `CHK(llc_en_o, 1'b0)
    sense_set[8] = 1'b1;
    wait_llc(1'b1, 8, 40);
    sense_set[8] = 1'b0;
    repeat (300) @(negedge clk_i);
    `CHK(repeat_cnt_o, 4'h0)
  endtask
  task automatic t_ovp;
    sense_set[0] = 1'b1;
    wait_llc(1'b0, 1, 8);
    `CHK(feedback_sense_pin_o, 8'hff)
    sense_set[0] = 1'b0;
    wait_llc(1'b1, 15, 45);
    `CHK(cause_o, 6'h05)
    @(negedge clk_i); cause_clr_i = 1'b1;
    @(negedge clk_i); cause_clr_i = 1'b0;
    @(negedge clk_i);
    `CHK(cause_o, 6'h00)
  endtask
  task automatic t_settings;
    int n;
    for (int m = 3; m >= 0; m--) begin
      wr(pmm_pkg::NV_MISC, {1'b0, 2'(m), 4'h0, 1'b1}, 1'b0);
      repeat (3) @(negedge clk_i);
      `CHK(pfc_mode_o, 2'(m))
      `CHK(pfc_en_o, 1'(m != 3))
      `CHK(pfc_softstart_o, 1'(m != 3))
    end
    `CHK(start_12v_o, 1'b1)
    `CHK(hv_startup_charge_path_o, 1'b0)
    sense_set[9] = 1'b1;
    repeat (1100) @(negedge clk_i);
    `CHK(xcap_dch_o, 1'b0)
    `CHK(pfc_softstart_o, 1'b0)
    sense_set[9] = 1'b0;
    wr(pmm_pkg::NV_MISC, 8'h09, 1'b0);
    repeat (5) @(negedge clk_i);
    sense_set[9] = 1'b1;
    n = 0;
    while (xcap_dch_o !== 1'b1 && n < 1100) begin @(negedge clk_i); n++; end
    `CHK(n >= 985 && n <= 1015, 1'b1)
  endtask
  // ****
  // Sequence and timeout
  // ****
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  initial begin
    repeat (2) @(negedge clk_i);
    srst_i = 1'b0;
    t_locks();
    t_opp();
    t_ovp();
    t_settings();
    results();
  end
endmodule // testbench
